// ==== bench/exec_core_sva.sv ====
// timing and flag assertions on the execution slice ports
// assumes a bind onto exec_core with one clock and sync reset
`timescale 1ns/1ps
module exec_core_sva import core_pkg::*; (
  input logic i_mclk,
  input logic i_rst,
  input logic i_cmd_valid,
  input cmd_s i_cmd,
  input logic [7:0] i_io_rdata,
  input logic o_ready,
  input logic o_done,
  input logic [15:0] o_pc,
  input logic [7:0] o_sreg,
  input logic o_dmem_re,
  input logic o_dmem_we,
  input logic o_pmem_re,
  input logic o_io_re,
  input logic o_io_we,
  input logic [7:0] o_io_wdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // command taken at this edge
  wire take = i_cmd_valid && o_ready;
  wire [15:0] br_tgt = o_pc + {{9{i_cmd.off[6]}}, i_cmd.off} + 16'h0001;
  wire [15:0] pc_nxt = o_pc + 16'h0001;
  wire is_bvc = take && (i_cmd.op == op_branch_overflow_clear);
  // busy one cycle then done
  sequence two_cyc;
    !o_ready ##1 (o_ready && o_done);
  endsequence
  bvc_taken_a: assert property (is_bvc && !o_sreg[SREG_V] |=>
    o_pc == $past(br_tgt) ##0 two_cyc) else $error("bvc taken bad");
  bvc_skip_a: assert property (is_bvc && o_sreg[SREG_V] |=>
    o_pc == $past(pc_nxt) && o_done && o_ready) else $error("bvc skip bad");
  irq_taken_a: assert property (take &&
    ((i_cmd.op == op_branch_irq_enabled && o_sreg[SREG_I]) ||
    (i_cmd.op == op_branch_irq_disabled && !o_sreg[SREG_I])) |=>
    o_pc == $past(br_tgt) ##0 two_cyc) else $error("irq branch bad");
  store_time_a: assert property ($rose(o_dmem_we) |-> two_cyc)
    else $error("store timing bad");
  load_time_a: assert property ($rose(o_dmem_re) |-> !o_ready ##1
    (o_done && !o_dmem_re)) else $error("load timing bad");
  flash_time_a: assert property ($rose(o_pmem_re) |->
    (o_pmem_re && !o_ready)[*2] ##1 (o_done && !o_pmem_re))
    else $error("flash read timing bad");
  io_time_a: assert property ($rose(o_io_re) |-> !o_ready ##1
    (o_io_we && o_done && !o_io_re)) else $error("io bit timing bad");
  io_one_bit_a: assert property (o_io_we |->
    $countones(o_io_wdata ^ $past(i_io_rdata)) <= 1)
    else $error("io write alters other bits");
  io_flags_a: assert property ($rose(o_io_re) |=> $stable(o_sreg))
    else $error("io bit changed flags");
  rot_flags_a: assert property (take && (i_cmd.op == op_rotate_left_carry
    || i_cmd.op == op_rotate_right_carry) |=> o_done &&
    o_sreg[SREG_V] == (o_sreg[SREG_N] ^ o_sreg[SREG_C]) &&
    o_sreg[SREG_T] == $past(o_sreg[SREG_T])) else $error("rotate flags bad");
  t_dep_a: assert property (take && i_cmd.op == op_t_flag_deposit |=>
    o_done && o_ready && o_sreg == $past(o_sreg)) else $error("deposit bad");
endmodule

// ==== bench/exec_core_tb.sv ====
// self-checking bench for the execution slice
// assumes mem_model as sram, flash and io; checker bound below
`timescale 1ns/1ps
module exec_core_tb;
  import core_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst;
  logic i_cmd_valid;
  cmd_s i_cmd;
  logic [7:0] dr, pr, ir;
  logic o_ready, o_done, o_dmem_re, o_dmem_we, o_pmem_re;
  logic o_io_re, o_io_we;
  logic [15:0] o_pc, o_sp, o_dmem_addr, o_pmem_addr;
  logic [7:0] o_sreg, o_dmem_wdata, o_io_wdata;
  logic [5:0] o_io_addr;
  int error_cnt = 0;
  int check_count = 0;
  always #10 i_mclk = ~i_mclk;
  exec_core i_exec_core(.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_dmem_rdata(dr),
    .i_pmem_rdata(pr), .i_io_rdata(ir), .o_ready(o_ready),
    .o_done(o_done), .o_pc(o_pc), .o_sp(o_sp), .o_sreg(o_sreg),
    .o_dmem_addr(o_dmem_addr), .o_dmem_re(o_dmem_re),
    .o_dmem_we(o_dmem_we), .o_dmem_wdata(o_dmem_wdata),
    .o_pmem_addr(o_pmem_addr), .o_pmem_re(o_pmem_re),
    .o_io_addr(o_io_addr), .o_io_re(o_io_re), .o_io_we(o_io_we),
    .o_io_wdata(o_io_wdata));
  mem_model i_mem_model(.i_mclk(i_mclk), .i_dmem_addr(o_dmem_addr),
    .i_dmem_re(o_dmem_re), .i_dmem_we(o_dmem_we),
    .i_dmem_wdata(o_dmem_wdata), .i_pmem_addr(o_pmem_addr),
    .i_pmem_re(o_pmem_re), .i_io_addr(o_io_addr), .i_io_re(o_io_re),
    .i_io_we(o_io_we), .i_io_wdata(o_io_wdata), .o_dmem_rdata(dr),
    .o_pmem_rdata(pr), .o_io_rdata(ir));
  // verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one compare, reported at once
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
      input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // build a command; k also feeds off, q, bit number and io address
  function automatic cmd_s mk(op_e op, mode_e m, ptr_e p, logic [4:0] r,
      logic [15:0] k);
    cmd_s c;
    c = '0;
    c.op = op;
    c.mode = m;
    c.ptr = p;
    c.rd = r;
    c.rr = r;
    c.k = k;
    c.off = k[6:0];
    c.q = k[5:0];
    c.bitn = k[2:0];
    c.io = k[13:8];
    return c;
  endfunction
  // offer one command, count cycles to done
  task automatic run(input cmd_s c, input int n);
    int k;
    @(negedge i_mclk);
    check({15'h0000, o_ready}, 16'h0001, "not ready");
    i_cmd = c;
    i_cmd_valid = 1'b1;
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
    k = 1;
    while (o_done !== 1'b1 && k < 6) begin
      @(negedge i_mclk);
      k++;
    end
    if (o_done !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t no done", $time);
      results();
    end
    check(16'(k), 16'(n), "cycle count");
  endtask
  task automatic ldi(input logic [4:0] r, input logic [7:0] v);
    run(mk(op_ldi, am_plain, ptr_x, r, {8'h00, v}), 1);
  endtask
  // store and judge the write seen by the sram
  task automatic st(input op_e op, input mode_e m, input ptr_e p,
      input logic [4:0] r, input logic [15:0] k, input logic [15:0] ea,
      input logic [7:0] ed);
    run(mk(op, m, p, r, k), 2);
    check(i_mem_model.last_waddr, ea, "write address");
    check({8'h00, i_mem_model.last_wdata}, {8'h00, ed}, "write data");
  endtask
  task automatic sc_branch(input op_e op, input logic [7:0] sr,
      input logic [6:0] off, input logic tk);
    logic [15:0] p0;
    run(mk(op_status_write, am_plain, ptr_x, 5'h00, {8'h00, sr}), 1);
    p0 = o_pc;
    run(mk(op, am_plain, ptr_x, 5'h00, {9'h000, off}), tk ? 2 : 1);
    check(o_pc, tk ? p0 + {{9{off[6]}}, off} + 16'h0001 : p0 + 16'h0001,
      "branch pc");
  endtask
  task automatic sc_pointer();
    i_mem_model.sram[8'hFF] = 8'h3C;
    ldi(5'h1A, 8'hFF);
    ldi(5'h1B, 8'h00);
    run(mk(op_load_indirect, am_post_inc, ptr_x, 5'h05, 0), 2);
    st(op_memory_write_indirect, am_plain, ptr_x, 5'h05, 0, 16'h0100,
      8'h3C);
    i_mem_model.sram[8'hFF] = 8'hA7;
    run(mk(op_load_indirect, am_pre_dec, ptr_x, 5'h06, 0), 2);
    st(op_memory_write_indirect, am_post_inc, ptr_x, 5'h06, 0, 16'h00FF,
      8'hA7);
    st(op_memory_write_indirect, am_pre_dec, ptr_x, 5'h06, 0, 16'h00FF,
      8'hA7);
  endtask
  task automatic sc_disp_direct();
    i_mem_model.sram[8'h15] = 8'h77;
    i_mem_model.sram[8'h40] = 8'h9E;
    ldi(5'h1C, 8'h10);
    ldi(5'h1D, 8'h00);
    run(mk(op_load_indirect, am_disp, ptr_y, 5'h07, 16'h0005), 2);
    st(op_memory_write_indirect, am_disp, ptr_y, 5'h07, 16'h0006,
      16'h0016, 8'h77);
    st(op_memory_write_indirect, am_plain, ptr_y, 5'h07, 0, 16'h0010,
      8'h77);
    run(mk(op_load_direct, am_plain, ptr_x, 5'h08, 16'h0040), 2);
    st(op_memory_write_direct, am_plain, ptr_x, 5'h08, 16'h0041,
      16'h0041, 8'h9E);
  endtask
  task automatic sc_flash();
    cmd_s c;
    ldi(5'h1E, 8'h33);
    ldi(5'h1F, 8'h00);
    c = mk(op_program_memory_read, am_plain, ptr_z, 5'h09, 0);
    c.use_r0 = 1'b1;
    run(c, 3);
    st(op_memory_write_direct, am_plain, ptr_x, 5'h00, 16'h0050,
      16'h0050, 8'h69);
    run(mk(op_program_memory_read, am_post_inc, ptr_z, 5'h09, 0), 3);
    st(op_memory_write_direct, am_plain, ptr_x, 5'h09, 16'h0051,
      16'h0051, 8'h69);
    run(mk(op_program_memory_read, am_plain, ptr_z, 5'h0A, 0), 3);
    st(op_memory_write_direct, am_plain, ptr_x, 5'h0A, 16'h0052,
      16'h0052, 8'h6E);
  endtask
  task automatic sc_stack_io();
    ldi(5'h0B, 8'hC3);
    st(op_push, am_plain, ptr_x, 5'h0B, 0, 16'h00FF, 8'hC3);
    check(o_sp, 16'h00FE, "sp after push");
    run(mk(op_pop, am_plain, ptr_x, 5'h0C, 0), 2);
    check(o_sp, 16'h00FF, "sp after pop");
    st(op_memory_write_direct, am_plain, ptr_x, 5'h0C, 16'h0060,
      16'h0060, 8'hC3);
    i_mem_model.io[5] = 8'h81;
    run(mk(op_io_bit_set, am_plain, ptr_x, 5'h00, 16'h0502), 2);
    @(negedge i_mclk);
    check({8'h00, i_mem_model.io[5]}, 16'h0085, "io set");
    run(mk(op_io_bit_clear, am_plain, ptr_x, 5'h00, 16'h0507), 2);
    @(negedge i_mclk);
    check({8'h00, i_mem_model.io[5]}, 16'h0005, "io clear");
  endtask
  task automatic sc_bits();
    cmd_s c;
    run(mk(op_status_write, am_plain, ptr_x, 5'h00, 16'h0001), 1);
    ldi(5'h0D, 8'h80);
    run(mk(op_rotate_left_carry, am_plain, ptr_x, 5'h0D, 0), 1);
    check({8'h00, o_sreg}, 16'h0009, "rol flags");
    st(op_memory_write_direct, am_plain, ptr_x, 5'h0D, 16'h0061,
      16'h0061, 8'h01);
    run(mk(op_rotate_right_carry, am_plain, ptr_x, 5'h0D, 0), 1);
    check({8'h00, o_sreg}, 16'h0005, "ror flags");
    st(op_memory_write_direct, am_plain, ptr_x, 5'h0D, 16'h0061,
      16'h0061, 8'h80);
    ldi(5'h0E, 8'h08);
    run(mk(op_t_flag_capture, am_plain, ptr_x, 5'h0E, 16'h0003), 1);
    check({8'h00, o_sreg}, 16'h0045, "t capture");
    ldi(5'h0F, 8'h00);
    run(mk(op_t_flag_deposit, am_plain, ptr_x, 5'h0F, 16'h0000), 1);
    st(op_memory_write_direct, am_plain, ptr_x, 5'h0F, 16'h0062,
      16'h0062, 8'h01);
    // register copy from r15 into r16, judged through a store
    c = mk(op_mov, am_plain, ptr_x, 5'h10, 16'h0000);
    c.rr = 5'h0F;
    run(c, 1);
    st(op_memory_write_direct, am_plain, ptr_x, 5'h10, 16'h0063,
      16'h0063, 8'h01);
  endtask
  // reset, then the scenarios in turn
  initial begin
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    check(o_sp, SP_RESET, "sp reset");
    check({8'h00, o_sreg}, {8'h00, SREG_RESET}, "sreg reset");
    sc_branch(op_branch_overflow_clear, 8'h00, 7'h05, 1'b1);
    sc_branch(op_branch_overflow_clear, 8'h08, 7'h05, 1'b0);
    sc_branch(op_branch_irq_enabled, 8'h80, 7'h7C, 1'b1);
    sc_branch(op_branch_irq_enabled, 8'h00, 7'h10, 1'b0);
    sc_branch(op_branch_irq_disabled, 8'h00, 7'h7E, 1'b1);
    sc_branch(op_branch_irq_disabled, 8'h80, 7'h10, 1'b0);
    sc_pointer();
    sc_disp_direct();
    sc_flash();
    sc_stack_io();
    sc_bits();
    results();
  end
endmodule
bind exec_core exec_core_sva i_exec_core_sva(.i_mclk(i_mclk),
  .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .i_io_rdata(i_io_rdata), .o_ready(o_ready), .o_done(o_done),
  .o_pc(o_pc), .o_sreg(o_sreg), .o_dmem_re(o_dmem_re),
  .o_dmem_we(o_dmem_we), .o_pmem_re(o_pmem_re), .o_io_re(o_io_re),
  .o_io_we(o_io_we), .o_io_wdata(o_io_wdata));

// ==== bench/mem_model.sv ====
// sram, flash and io space answering combinationally
// assumes the core clock; released read data shows a changing filler
`timescale 1ns/1ps
module mem_model (
  input logic i_mclk,
  input logic [15:0] i_dmem_addr,
  input logic i_dmem_re,
  input logic i_dmem_we,
  input logic [7:0] i_dmem_wdata,
  input logic [15:0] i_pmem_addr,
  input logic i_pmem_re,
  input logic [5:0] i_io_addr,
  input logic i_io_re,
  input logic i_io_we,
  input logic [7:0] i_io_wdata,
  output logic [7:0] o_dmem_rdata,
  output logic [7:0] o_pmem_rdata,
  output logic [7:0] o_io_rdata
);
  logic [7:0] sram [256]; // low address byte only
  logic [7:0] io [64]; // io register space
  logic [15:0] last_waddr = 16'h0000; // last sram write seen
  logic [7:0] last_wdata = 8'h00;
  logic [7:0] junk = 8'h5C; // filler, all bits but 0 and 5 flip every cycle
  // read answers, filler while not strobed
  assign o_dmem_rdata = i_dmem_re ? sram[i_dmem_addr[7:0]] : junk;
  assign o_pmem_rdata = i_pmem_re ? (i_pmem_addr[7:0] ^ 8'h5A) : junk;
  assign o_io_rdata = i_io_re ? io[i_io_addr] : junk;
  // write strobes land at the clock edge
  always @(posedge i_mclk) begin
    junk <= ~junk ^ 8'h21;
    if (i_dmem_we) begin
      sram[i_dmem_addr[7:0]] <= i_dmem_wdata;
      last_waddr <= i_dmem_addr;
      last_wdata <= i_dmem_wdata;
    end
    if (i_io_we) begin
      io[i_io_addr] <= i_io_wdata;
    end
  end
endmodule

// ==== logic/bit_unit.sv ====
// rotate, bit transfer and io bit modify datapath
// assumes operand and op are selected by the caller
`timescale 1ns/1ps
module bit_unit import core_pkg::*; (
  input logic [7:0] i_val,
  input op_e i_op,
  input logic i_c,
  input logic i_t,
  input logic [2:0] i_bitn,
  output logic [7:0] o_res,
  output logic o_c,
  output logic o_t,
  output logic o_z,
  output logic o_n,
  output logic o_v
);
  logic [7:0] mask; // one-hot bit select
  assign mask = 8'h01 << i_bitn;
  // result per op
  assign o_res =
    (i_op == op_rotate_left_carry) ? {i_val[6:0], i_c} :
    (i_op == op_rotate_right_carry) ? {i_c, i_val[7:1]} :
    (i_op == op_io_bit_set) ? (i_val | mask) :
    (i_op == op_io_bit_clear) ? (i_val & ~mask) :
    (i_op == op_t_flag_deposit) ?
      (i_t ? (i_val | mask) : (i_val & ~mask)) : i_val;
  // carry out of the rotates
  assign o_c = (i_op == op_rotate_left_carry) ? i_val[7] : i_val[0];
  assign o_t = i_val[i_bitn];
  assign o_z = (o_res == 8'h00);
  assign o_n = o_res[7];
  assign o_v = o_n ^ o_c;
endmodule

// ==== logic/core_pkg.sv ====
// constants, enums and the command carrier of the execution slice
// assumes one core clock shared with sram, flash and io space
package core_pkg;
  // cycle counts per instruction group
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
  localparam logic [1:0] CYC_MEM = 2'h2;
  localparam logic [1:0] CYC_PROG = 2'h3;
  localparam logic [1:0] CYC_STACK = 2'h2;
  localparam logic [1:0] CYC_IO_BIT = 2'h2;
  // status bit positions
  localparam int unsigned SREG_C = 0;
  localparam int unsigned SREG_Z = 1;
  localparam int unsigned SREG_N = 2;
  localparam int unsigned SREG_V = 3;
  localparam int unsigned SREG_T = 6;
  localparam int unsigned SREG_I = 7;
  // reset values
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  // low byte index of each pointer pair, and of r0
  localparam logic [4:0] X_IDX = 5'h1A;
  localparam logic [4:0] Y_IDX = 5'h1C;
  localparam logic [4:0] Z_IDX = 5'h1E;
  localparam logic [4:0] R0_IDX = 5'h00;

  typedef enum logic [4:0] {
    op_nop, op_branch_overflow_clear, op_branch_irq_enabled,
    op_branch_irq_disabled, op_mov, op_ldi, op_load_indirect,
    op_memory_write_indirect, op_load_direct, op_memory_write_direct,
    op_program_memory_read, op_push, op_pop, op_io_bit_set,
    op_io_bit_clear, op_rotate_left_carry, op_rotate_right_carry,
    op_t_flag_capture, op_t_flag_deposit, op_status_write
  } op_e;
  typedef enum logic [1:0] {am_plain, am_post_inc, am_pre_dec, am_disp}
    mode_e;
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_e;
  typedef enum logic {st_idle, st_busy} state_e;

  // one decoded instruction
  typedef struct packed {
    op_e op;
    mode_e mode;
    ptr_e ptr;
    logic use_r0;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [5:0] q;
    logic [2:0] bitn;
    logic [5:0] io;
    logic [15:0] k;
    logic [6:0] off;
  } cmd_s;
endpackage

// ==== logic/exec_core.sv ====
// execution slice: branches, data moves, flash read, stack, bit ops
// assumes sram, flash and io answer combinationally to held address
`timescale 1ns/1ps
module exec_core import core_pkg::*; (
  input logic i_mclk,
  input logic i_rst,
  input logic i_cmd_valid,
  input cmd_s i_cmd,
  input logic [7:0] i_dmem_rdata,
  input logic [7:0] i_pmem_rdata,
  input logic [7:0] i_io_rdata,
  output logic o_ready,
  output logic o_done,
  output logic [15:0] o_pc,
  output logic [15:0] o_sp,
  output logic [7:0] o_sreg,
  output logic [15:0] o_dmem_addr,
  output logic o_dmem_re,
  output logic o_dmem_we,
  output logic [7:0] o_dmem_wdata,
  output logic [15:0] o_pmem_addr,
  output logic o_pmem_re,
  output logic [5:0] o_io_addr,
  output logic o_io_re,
  output logic o_io_we,
  output logic [7:0] o_io_wdata
);
  // low byte index of a pointer pair
  function automatic logic [4:0] ptr_base(input ptr_e p);
    ptr_base = (p == ptr_x) ? X_IDX : (p == ptr_y) ? Y_IDX : Z_IDX;
  endfunction

  // architectural state
  logic [7:0] rf [32]; // register file
  logic [15:0] pc; // program counter
  logic [15:0] sp; // stack pointer
  logic [7:0] sreg; // status flags
  state_e state; // idle or multi-cycle
  logic [1:0] remain; // cycles left
  cmd_s cur; // command in flight
  logic ready; // accepts a command
  logic done; // completion pulse
  // memory port flops
  logic [15:0] dmem_addr;
  logic dmem_re;
  logic dmem_we;
  logic [7:0] dmem_wdata;
  logic [15:0] pmem_addr;
  logic pmem_re;
  logic [5:0] io_addr;
  logic io_re;
  logic io_we;
  logic [7:0] io_wdata;

  // next values
  state_e next_state;
  logic [1:0] next_remain;
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [7:0] next_sreg;
  logic next_done;
  logic [15:0] next_dmem_addr;
  logic next_dmem_re;
  logic next_dmem_we;
  logic [7:0] next_dmem_wdata;
  logic [15:0] next_pmem_addr;
  logic next_pmem_re;
  logic [5:0] next_io_addr;
  logic next_io_re;
  logic next_io_we;
  logic [7:0] next_io_wdata;
  logic [1:0] cyc; // cycles of the taken command
  // register file write ports
  logic rf_we;
  logic [4:0] rf_widx;
  logic [7:0] rf_wdata;
  logic ptr_we;
  logic [4:0] ptr_idx;
  logic [15:0] ptr_wdata;

  // decode of the offered command
  logic take; // command accepted this edge
  logic finish; // last edge of a multi-cycle command
  logic [4:0] pidx; // selected pointer low index
  logic [4:0] pidx_hi; // selected pointer high index
  logic [15:0] ptr_val; // selected pointer value
  logic [15:0] ea; // effective data address
  logic [15:0] ptr_new; // stepped pointer
  logic stepping; // mode changes the pointer
  logic [7:0] rd_val; // destination operand
  logic [7:0] rr_val; // source operand
  logic br_taken; // branch condition true
  logic [15:0] br_target; // relative target
  logic [15:0] pc_next1; // next word
  logic [15:0] pc_next2; // skip second word
  logic [4:0] lpm_dst; // flash read destination

  assign take = ready & i_cmd_valid;
  assign finish = (state == st_busy) & (remain == 2'h1);
  // flash reads always go through z
  assign pidx = (i_cmd.op == op_program_memory_read) ? Z_IDX :
    ptr_base(i_cmd.ptr);
  assign pidx_hi = pidx + 5'h01;
  assign ptr_val = {rf[pidx_hi], rf[pidx]};
  assign stepping = (i_cmd.mode == am_post_inc) |
    (i_cmd.mode == am_pre_dec);
  assign rd_val = rf[i_cmd.rd];
  assign rr_val = rf[i_cmd.rr];
  assign br_taken =
    ((i_cmd.op == op_branch_overflow_clear) & ~sreg[SREG_V]) |
    ((i_cmd.op == op_branch_irq_enabled) & sreg[SREG_I]) |
    ((i_cmd.op == op_branch_irq_disabled) & ~sreg[SREG_I]);
  assign br_target = pc + {{9{i_cmd.off[6]}}, i_cmd.off} + 16'h0001;
  assign pc_next1 = pc + 16'h0001;
  assign pc_next2 = pc + 16'h0002;
  assign lpm_dst = cur.use_r0 ? R0_IDX : cur.rd;

  ptr_unit u_ptr (
    .i_ptr(ptr_val),
    .i_mode(i_cmd.mode),
    .i_q(i_cmd.q),
    .o_addr(ea),
    .o_ptr(ptr_new)
  );

  // bit unit sees io data while an io bit op finishes
  logic bu_io; // io modify phase
  logic [7:0] bu_in;
  op_e bu_op;
  logic [2:0] bu_bitn;
  logic [7:0] bu_res;
  logic bu_c;
  logic bu_t;
  logic bu_z;
  logic bu_n;
  logic bu_v;
  assign bu_io = (state == st_busy);
  assign bu_in = bu_io ? i_io_rdata : rd_val;
  assign bu_op = bu_io ? cur.op : i_cmd.op;
  assign bu_bitn = bu_io ? cur.bitn : i_cmd.bitn;

  bit_unit u_bit (
    .i_val(bu_in),
    .i_op(bu_op),
    .i_c(sreg[SREG_C]),
    .i_t(sreg[SREG_T]),
    .i_bitn(bu_bitn),
    .o_res(bu_res),
    .o_c(bu_c),
    .o_t(bu_t),
    .o_z(bu_z),
    .o_n(bu_n),
    .o_v(bu_v)
  );

  // sequencing and datapath control
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_pc = pc;
    next_sp = sp;
    next_sreg = sreg;
    next_done = 1'b0;
    next_dmem_addr = dmem_addr;
    next_dmem_re = dmem_re;
    next_dmem_we = 1'b0;
    next_dmem_wdata = dmem_wdata;
    next_pmem_addr = pmem_addr;
    next_pmem_re = pmem_re;
    next_io_addr = io_addr;
    next_io_re = io_re;
    next_io_we = 1'b0;
    next_io_wdata = io_wdata;
    cyc = CYC_ONE;
    rf_we = 1'b0;
    rf_widx = i_cmd.rd;
    rf_wdata = 8'h00;
    ptr_we = 1'b0;
    ptr_idx = pidx;
    ptr_wdata = ptr_new;
    if (take) begin
      next_pc = pc_next1;
      case (i_cmd.op)
        // conditional relative branches
        op_branch_overflow_clear, op_branch_irq_enabled,
        op_branch_irq_disabled: begin
          if (br_taken) begin
            next_pc = br_target;
            cyc = CYC_BR_TAKEN;
          end
        end
        // register copy and immediate load
        op_mov: begin
          rf_we = 1'b1;
          rf_wdata = rr_val;
        end
        op_ldi: begin
          rf_we = 1'b1;
          rf_wdata = i_cmd.k[7:0];
        end
        // indirect load, data caught on the last edge
        op_load_indirect: begin
          next_dmem_addr = ea;
          next_dmem_re = 1'b1;
          ptr_we = stepping;
          cyc = CYC_MEM;
        end
        // indirect store
        op_memory_write_indirect: begin
          next_dmem_addr = ea;
          next_dmem_we = 1'b1;
          next_dmem_wdata = rr_val;
          ptr_we = stepping;
          cyc = CYC_MEM;
        end
        // direct forms carry a second word
        op_load_direct: begin
          next_pc = pc_next2;
          next_dmem_addr = i_cmd.k;
          next_dmem_re = 1'b1;
          cyc = CYC_MEM;
        end
        op_memory_write_direct: begin
          next_pc = pc_next2;
          next_dmem_addr = i_cmd.k;
          next_dmem_we = 1'b1;
          next_dmem_wdata = rr_val;
          cyc = CYC_MEM;
        end
        // flash byte read through z
        op_program_memory_read: begin
          next_pmem_addr = ptr_val;
          next_pmem_re = 1'b1;
          ptr_we = (i_cmd.mode == am_post_inc);
          cyc = CYC_PROG;
        end
        // stack grows downward, push writes then lowers
        op_push: begin
          next_dmem_addr = sp;
          next_dmem_we = 1'b1;
          next_dmem_wdata = rr_val;
          next_sp = sp - 16'h0001;
          cyc = CYC_STACK;
        end
        op_pop: begin
          next_sp = sp + 16'h0001;
          next_dmem_addr = sp + 16'h0001;
          next_dmem_re = 1'b1;
          cyc = CYC_STACK;
        end
        // io read now, modified write on the last edge
        op_io_bit_set, op_io_bit_clear: begin
          next_io_addr = i_cmd.io;
          next_io_re = 1'b1;
          cyc = CYC_IO_BIT;
        end
        // rotates through carry
        op_rotate_left_carry, op_rotate_right_carry: begin
          rf_we = 1'b1;
          rf_wdata = bu_res;
          next_sreg[SREG_C] = bu_c;
          next_sreg[SREG_Z] = bu_z;
          next_sreg[SREG_N] = bu_n;
          next_sreg[SREG_V] = bu_v;
        end
        // bit transfer flag
        op_t_flag_capture: begin
          next_sreg[SREG_T] = bu_t;
        end
        op_t_flag_deposit: begin
          rf_we = 1'b1;
          rf_wdata = bu_res;
        end
        // whole status write for setup
        op_status_write: begin
          next_sreg = i_cmd.k[7:0];
        end
        default: begin
          next_pc = pc_next1;
        end
      endcase
      // one-cycle commands finish at once
      if (cyc == CYC_ONE) begin
        next_done = 1'b1;
      end else begin
        next_state = st_busy;
        next_remain = cyc - 2'h1;
      end
    end else if (finish) begin
      next_state = st_idle;
      next_remain = 2'h0;
      next_done = 1'b1;
      next_dmem_re = 1'b0;
      next_pmem_re = 1'b0;
      next_io_re = 1'b0;
      rf_widx = cur.rd;
      case (cur.op)
        // capture read data into the destination
        op_load_indirect, op_load_direct, op_pop: begin
          rf_we = 1'b1;
          rf_wdata = i_dmem_rdata;
        end
        op_program_memory_read: begin
          rf_we = 1'b1;
          rf_widx = lpm_dst;
          rf_wdata = i_pmem_rdata;
        end
        // write back with one bit forced
        op_io_bit_set, op_io_bit_clear: begin
          next_io_we = 1'b1;
          next_io_wdata = bu_res;
        end
        default: begin
          rf_we = 1'b0;
        end
      endcase
    end else if (state == st_busy) begin
      next_remain = remain - 2'h1;
    end
  end

  // register file, pointer write lands on both bytes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int i = 0; i < 32; i++) begin
        rf[i] <= 8'h00;
      end
    end else begin
      if (ptr_we) begin
        rf[ptr_idx] <= ptr_wdata[7:0];
        rf[ptr_idx + 5'h01] <= ptr_wdata[15:8];
      end
      if (rf_we) begin
        rf[rf_widx] <= rf_wdata;
      end
    end
  end

  // control state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= st_idle;
      remain <= 2'h0;
      ready <= 1'b1;
      done <= 1'b0;
      pc <= PC_RESET;
      sp <= SP_RESET;
      sreg <= SREG_RESET;
      cur <= '0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      ready <= (next_state == st_idle);
      done <= next_done;
      pc <= next_pc;
      sp <= next_sp;
      sreg <= next_sreg;
      if (take) begin
        cur <= i_cmd;
      end
    end
  end

  // memory and io port flops
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dmem_addr <= 16'h0000;
      dmem_re <= 1'b0;
      dmem_we <= 1'b0;
      dmem_wdata <= 8'h00;
      pmem_addr <= 16'h0000;
      pmem_re <= 1'b0;
      io_addr <= 6'h00;
      io_re <= 1'b0;
      io_we <= 1'b0;
      io_wdata <= 8'h00;
    end else begin
      dmem_addr <= next_dmem_addr;
      dmem_re <= next_dmem_re;
      dmem_we <= next_dmem_we;
      dmem_wdata <= next_dmem_wdata;
      pmem_addr <= next_pmem_addr;
      pmem_re <= next_pmem_re;
      io_addr <= next_io_addr;
      io_re <= next_io_re;
      io_we <= next_io_we;
      io_wdata <= next_io_wdata;
    end
  end

  // outputs straight from flops
  assign o_ready = ready;
  assign o_done = done;
  assign o_pc = pc;
  assign o_sp = sp;
  assign o_sreg = sreg;
  assign o_dmem_addr = dmem_addr;
  assign o_dmem_re = dmem_re;
  assign o_dmem_we = dmem_we;
  assign o_dmem_wdata = dmem_wdata;
  assign o_pmem_addr = pmem_addr;
  assign o_pmem_re = pmem_re;
  assign o_io_addr = io_addr;
  assign o_io_re = io_re;
  assign o_io_we = io_we;
  assign o_io_wdata = io_wdata;
endmodule

// ==== logic/ptr_unit.sv ====
// effective address and updated pointer for indirect forms
// assumes pointer value already read from the register file
`timescale 1ns/1ps
module ptr_unit import core_pkg::*; (
  input logic [15:0] i_ptr,
  input mode_e i_mode,
  input logic [5:0] i_q,
  output logic [15:0] o_addr,
  output logic [15:0] o_ptr
);
  logic [15:0] inc; // pointer plus one
  logic [15:0] dec; // pointer minus one
  logic [15:0] disp; // pointer plus displacement
  assign inc = i_ptr + 16'h0001;
  assign dec = i_ptr - 16'h0001;
  assign disp = i_ptr + {10'h000, i_q};
  // pre-dec addresses the lowered pointer
  assign o_addr = (i_mode == am_pre_dec) ? dec :
    (i_mode == am_disp) ? disp : i_ptr;
  // only the stepping forms change the pointer
  assign o_ptr = (i_mode == am_post_inc) ? inc :
    (i_mode == am_pre_dec) ? dec : i_ptr;
endmodule
